// ==== rtl/pdo_top.sv ====
//----------------------------------------------------------------------
// Purpose: Hysteresis gating, dead-time, state and level selection
// Assumes: timer_tick is a one-cycle pulse per main timer clock step
// Notes:   Outputs are registered, one cycle behind the state bits
//----------------------------------------------------------------------
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps

module pdo_top
	import pdo_pkg::*;
(
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           rst,
	// Register bus
	input  wire pdo_wb_req_s    wb_req,
	output pdo_wb_rsp_s         wb_rsp,
	// Compare logic side
	input  wire logic           timer_tick,
	input  wire logic           timer_shadow_transfer,
	input  wire logic [NCH-1:0] channel_state_req,
	// Comparator pins
	input  wire logic [NCH-1:0] comparator_input,
	// Phase outputs toward modulation stage
	output pdo_phase_s          phase_out
);

	pdo_state_s q;
	pdo_state_s d;

	logic           acc;
	logic           wr;
	logic           deadtime_reset_w;
	logic [NCH-1:0] mask;
	logic [NCH-1:0] dir_st;
	logic [NCH-1:0] inv_st;
	logic [NCH-1:0] main_act;
	logic [NCH-1:0] comp_act;
	logic [NCH-1:0] busy;
	logic [31:0]    rd_val;

	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction : byte_merge

	function automatic logic [31:0] dtc_word(input logic [DTM_W-1:0] len,
		input logic [NCH-1:0] en, input logic [NCH-1:0] bsy);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[DTC_DTM_LSB +: DTM_W] = len;
		r[DTC_EN_LSB +: NCH]    = en;
		r[DTC_BUSY_LSB +: NCH]  = bsy;
		return r;
	endfunction : dtc_word

	//------------------------------------------------------------------
	// Next state
	//------------------------------------------------------------------
	always_comb begin
		logic [31:0] m;
		m        = 32'h0000_0000;
		d        = q;
		acc      = wb_req.cyc & wb_req.stb & ~q.ack;
		wr       = acc & wb_req.we;
		deadtime_reset_w  = wr & (wb_req.adr == ADR_CTRL) & wb_req.sel[0] & wb_req.dat[CTRL_DEADTIME_RESET_BIT];
		d.ack    = acc;

		for (int i = 0; i < NCH; i++) begin
			busy[i] = q.dten[i] & (q.cnt[i] != '0);
		end

		// Read mux; PSL reads return the bits in use, not the shadow
		unique case (wb_req.adr)
			ADR_MODE: rd_val = {20'h00000, q.mode};
			ADR_DTC:  rd_val = dtc_word(q.deadtime_length, q.dten, busy);
			ADR_STAT: rd_val = {18'h00000, q.sel, 5'h00, q.st};
			ADR_PSL:  rd_val = {26'h0000000, q.psl_act};
			default:  rd_val = 32'h0000_0000;
		endcase
		d.rdat = (acc & ~wb_req.we) ? rd_val : 32'h0000_0000;

		if (wr) begin
			unique case (wb_req.adr)
				ADR_MODE: begin
					m      = byte_merge({20'h00000, q.mode}, wb_req.dat, wb_req.sel);
					d.mode = m[NCH*MODE_W-1:0];
				end
				ADR_DTC: begin
					m      = byte_merge(dtc_word(q.deadtime_length, q.dten, 3'h0), wb_req.dat, wb_req.sel);
					d.deadtime_length  = m[DTC_DTM_LSB +: DTM_W];
					d.dten = m[DTC_EN_LSB +: NCH];
				end
				ADR_STAT: begin
					m     = byte_merge({18'h00000, q.sel, 8'h00}, wb_req.dat, wb_req.sel);
					d.sel = m[STAT_SEL_LSB +: 2*NCH];
				end
				ADR_PSL: begin
					m        = byte_merge({26'h0000000, q.psl_sh}, wb_req.dat, wb_req.sel);
					d.psl_sh = m[2*NCH-1:0];
				end
				default: begin
					m = 32'h0000_0000;
				end
			endcase
		end

		// Shadow transfer wins over nothing; a same-cycle write lands next transfer
		if (timer_shadow_transfer) begin
			d.psl_act = q.psl_sh;
		end

		// Comparator pin filter: three stages, change accepted when last two agree
		d.s1 = comparator_input;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < NCH; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.cmp_f[i] = q.s3[i];
			end
		end

		for (int i = 0; i < NCH; i++) begin
			// Hysteresis gating of the state bit
			if (q.mode[i] == MODE_HYST && !q.cmp_f[i]) begin
				d.st[i] = 1'b0;
			end else begin
				d.st[i] = channel_state_req[i];
			end

			// Dead-time counter
			if (deadtime_reset_w) begin
				d.cnt[i]  = '0;
				d.seen[i] = q.st[i];
			end else if (!q.dten[i]) begin
				d.cnt[i]  = '0;
				d.seen[i] = q.st[i];
			end else if (q.cnt[i] != '0) begin
				// Changes wait; an early flip would otherwise add a second dead-time
				if (timer_tick) begin
					d.cnt[i] = DTM_W'(q.cnt[i] - 1'b1);
				end
			end else if (q.st[i] != q.seen[i]) begin
				d.seen[i] = q.st[i];
				d.cnt[i]  = q.deadtime_length;
			end

			// Mask is low while a change is pending or the counter runs
			mask[i]   = ~q.dten[i] | ((q.cnt[i] == '0) & (q.seen[i] == q.st[i]));
			dir_st[i] = q.st[i] & mask[i];
			inv_st[i] = ~q.st[i] & mask[i];

			// Select bit set swaps the output to the other side of the compare value
			main_act[i] = q.sel[2*i] ? inv_st[i] : dir_st[i];
			comp_act[i] = q.sel[2*i+1] ? dir_st[i] : inv_st[i];
			d.ph.main_phase_output[i]          = q.psl_act[2*i] ^ main_act[i];
			d.ph.complementary_phase_output[i] = q.psl_act[2*i+1] ^ comp_act[i];
		end
	end

	//------------------------------------------------------------------
	// State register
	//------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			q         <= '0;
			q.deadtime_length     <= RST_DTM;
			q.dten    <= RST_DTEN;
			q.sel     <= RST_SEL;
			q.psl_sh  <= RST_PSL;
			q.psl_act <= RST_PSL;
		end else begin
			q <= d;
		end
	end

	assign wb_rsp.ack = q.ack;
	assign wb_rsp.dat = q.rdat;
	assign phase_out  = q.ph;

	//------------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	for (genvar g = 0; g < NCH; g++) begin : g_chk

		property p_hyst_clear;
			(q.mode[g] == MODE_HYST && !q.cmp_f[g]) |=> !q.st[g];
		endproperty
		a_hyst_clear: assert property (p_hyst_clear) else $error("state bit not held low");

		property p_hyst_noset;
			($rose(q.st[g]) && $past(q.mode[g]) == MODE_HYST) |-> $past(q.cmp_f[g]);
		endproperty
		a_hyst_noset: assert property (p_hyst_noset) else $error("state bit set with input low");

		property p_hyst_follow;
			(q.mode[g] == MODE_HYST && q.cmp_f[g]) |=> (q.st[g] == $past(channel_state_req[g]));
		endproperty
		a_hyst_follow: assert property (p_hyst_follow) else $error("state bit not following");

		property p_cmp_filter;
			$changed(q.cmp_f[g]) |-> (q.cmp_f[g] == $past(comparator_input[g], 3))
				&& (q.cmp_f[g] == $past(comparator_input[g], 4));
		endproperty
		a_cmp_filter: assert property (p_cmp_filter) else $error("filter took unstable input");

		property p_excl;
			!(dir_st[g] && inv_st[g]);
		endproperty
		a_excl: assert property (p_excl) else $error("direct and inverted both active");

		property p_dead_passive;
			(q.dten[g] && q.cnt[g] != '0) |-> (!dir_st[g] && !inv_st[g]);
		endproperty
		a_dead_passive: assert property (p_dead_passive) else $error("output active in dead-time");

		property p_fall_fast;
			($fell(q.st[g]) && !q.sel[2*g]) |=> (q.ph.main_phase_output[g] == $past(q.psl_act[2*g]));
		endproperty
		a_fall_fast: assert property (p_fall_fast) else $error("falling edge delayed");

		property p_count_down;
			(busy[g] && timer_tick && !deadtime_reset_w && q.dten[g])
				|=> (q.cnt[g] == DTM_W'($past(q.cnt[g]) - 1'b1));
		endproperty
		a_count_down: assert property (p_count_down) else $error("counter missed a tick");

		property p_hold;
			(busy[g] && !timer_tick && !deadtime_reset_w && q.dten[g]) |=> $stable(q.cnt[g]) && $stable(q.seen[g]);
		endproperty
		a_hold: assert property (p_hold) else $error("counter moved without tick");

		property p_start;
			(q.dten[g] && q.cnt[g] == '0 && q.st[g] != q.seen[g] && !deadtime_reset_w) |=> (q.cnt[g] == $past(q.deadtime_length));
		endproperty
		a_start: assert property (p_start) else $error("counter not loaded on change");

		property p_level;
			##1 (q.ph.main_phase_output[g] == $past(q.psl_act[2*g] ^ main_act[g]));
		endproperty
		a_level: assert property (p_level) else $error("main pin level wrong");

		c_dead: cover property ($rose(q.st[g]) ##1 busy[g] [*2] ##[1:300] dir_st[g]);
	end

	property p_deadtime_reset;
		deadtime_reset_w |=> (q.cnt == '0);
	endproperty
	a_deadtime_reset: assert property (p_deadtime_reset) else $error("dead-time reset ignored");

	property p_psl_shadow;
		$changed(q.psl_act) |-> $past(timer_shadow_transfer);
	endproperty
	a_psl_shadow: assert property (p_psl_shadow) else $error("passive level changed early");

	c_hyst:  cover property (q.mode[0] == MODE_HYST && $fell(q.cmp_f[0]) ##1 !q.st[0]);
	c_reset: cover property (busy[0] && deadtime_reset_w);
	c_xfer:  cover property (timer_shadow_transfer && q.psl_sh != q.psl_act);

endmodule : pdo_top

// ==== rtl/pdo_pkg.sv ====
//----------------------------------------------------------------------
// Purpose: Constants and types for the per-channel PWM output path
// Assumes: 32-bit classic Wishbone slave, one clock, synchronous reset
// Notes:   Functional notes below; offsets are byte addresses
//----------------------------------------------------------------------

package pdo_pkg;

	localparam int NCH    = 3;
	localparam int DTM_W  = 8;
	localparam int MODE_W = 4;

	localparam logic [MODE_W-1:0] MODE_HYST = 4'h9;

	//------------------------------------------------------------------
	// Register map
	//------------------------------------------------------------------
	localparam logic [7:0] ADR_MODE = 8'h00;
	localparam logic [7:0] ADR_DTC  = 8'h04;
	localparam logic [7:0] ADR_CTRL = 8'h08;
	localparam logic [7:0] ADR_STAT = 8'h0C;
	localparam logic [7:0] ADR_PSL  = 8'h10;

	localparam int DTC_DTM_LSB    = 0;
	localparam int DTC_EN_LSB     = 8;
	localparam int DTC_BUSY_LSB   = 16;
	localparam int CTRL_DEADTIME_RESET_BIT = 0;
	localparam int STAT_ST_LSB    = 0;
	localparam int STAT_SEL_LSB   = 8;

	localparam logic [DTM_W-1:0]  RST_DTM  = 8'h00;
	localparam logic [NCH-1:0]    RST_DTEN = 3'h0;
	localparam logic [2*NCH-1:0]  RST_SEL  = 6'h00;
	localparam logic [2*NCH-1:0]  RST_PSL  = 6'h00;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} pdo_wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} pdo_wb_rsp_s;

	typedef struct packed {
		logic [NCH-1:0] main_phase_output;
		logic [NCH-1:0] complementary_phase_output;
	} pdo_phase_s;

	typedef struct packed {
		logic [NCH-1:0][MODE_W-1:0] mode;
		logic [DTM_W-1:0]           deadtime_length;
		logic [NCH-1:0]             dten;
		logic [2*NCH-1:0]           sel;
		logic [2*NCH-1:0]           psl_sh;
		logic [2*NCH-1:0]           psl_act;
		logic [NCH-1:0]             s1;
		logic [NCH-1:0]             s2;
		logic [NCH-1:0]             s3;
		logic [NCH-1:0]             cmp_f;
		logic [NCH-1:0]             st;
		logic [NCH-1:0]             seen;
		logic [NCH-1:0][DTM_W-1:0]  cnt;
		pdo_phase_s                 ph;
		logic                       ack;
		logic [31:0]                rdat;
	} pdo_state_s;

endpackage : pdo_pkg

// ==== sim/pdo_gate_drv.sv ====
//----------------------------------------------------------------------
// Purpose: Gate driver pair model for three inverter legs
// Assumes: Pin level 1 switches a power device on
// Notes:   Counts cycles in which both switches of one leg conduct
//----------------------------------------------------------------------
`timescale 1ns/10ps

module pdo_gate_drv (
	// Clock
	input  wire logic       clk,
	// Gate levels
	input  wire logic [2:0] high_side,
	input  wire logic [2:0] low_side,
	// Result
	output int              shoots
);
	int n_both = 0;
	// Passive level 0 keeps the switch off, so both high means shoot-through
	always @(posedge clk) begin
		if ((high_side & low_side) != 3'h0) begin
			n_both <= n_both + 1;
		end
	end
	assign shoots = n_both;
endmodule : pdo_gate_drv

// ==== sim/testbench.sv ====
//----------------------------------------------------------------------
// Purpose: Self-checking bench for the PWM output path
// Assumes: Timer tick every cycle except in t_tick, so counts are in clk cycles
// Notes:   Pin checks are taken at the falling edge, after updates settle, but t_hyst checks main at the ack edge; bus reads at the ack edge
//----------------------------------------------------------------------
`timescale 1ns/10ps

module testbench;
	import pdo_pkg::*;
	logic        clk;
	logic        rst;
	pdo_wb_req_s req;
	pdo_wb_rsp_s rsp;
	logic        tick;
	logic        sht;
	logic [2:0]  st_req;
	logic [2:0]  cmp;
	pdo_phase_s  ph;
	int          shoots;
	int          miscompares;
	int          n_tests;
	logic [31:0] rd;

	pdo_top pdo_top_i (.clk(clk), .rst(rst), .wb_req(req), .wb_rsp(rsp), .timer_tick(tick),
		.timer_shadow_transfer(sht), .channel_state_req(st_req), .comparator_input(cmp), .phase_out(ph));
	pdo_gate_drv pdo_gate_drv_i (.clk(clk), .high_side(ph.main_phase_output),
		.low_side(ph.complementary_phase_output), .shoots(shoots));

	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	task report_and_stop;
		$display("tests %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	// Classic cycle: hold until ack is sampled, release at that edge
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		req <= '{1'b1, 1'b1, w, a, 4'hF, d};
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (rsp.ack !== 1'b1 && i < 20);
		rd = rsp.dat;
		req <= '0;
		if (rsp.ack !== 1'b1) begin
			miscompares++;
			report_and_stop();
		end
	endtask : wb

	task drive(input logic [2:0] s, input int wait_n);
		@(posedge clk);
		st_req <= s;
		repeat (wait_n) @(negedge clk);
	endtask : drive

	//------------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------------
	task t_reset;
		@(posedge clk);
		@(negedge clk);
		chk("compl", 32'h7, ph.complementary_phase_output);
		chk("main", 32'h0, ph.main_phase_output);
		wb(1'b0, ADR_DTC, 32'h0);
		chk("dtc", 32'h0, rd);
		wb(1'b1, 8'h40, 32'hFFFF_FFFF);
		wb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, rd);
	endtask : t_reset

	task t_nodt;
		drive(3'h7, 3);
		chk("main", 32'h7, ph.main_phase_output);
		chk("compl", 32'h0, ph.complementary_phase_output);
		drive(3'h0, 3);
	endtask : t_nodt

	// Rising edge waits for the dead-time, falling edge does not
	task t_dt;
		int k;
		wb(1'b1, ADR_DTC, 32'h0000_0704);
		drive(3'h7, 0);
		for (k = 1; k < 12 && ph.main_phase_output !== 3'h7; k++) begin
			@(negedge clk);
			if (k == 4) chk("both", 32'h0, {ph.main_phase_output, ph.complementary_phase_output});
		end
		chk("delay", 32'h1, 32'(k >= 7 && k <= 10));
		drive(3'h0, 3);
		chk("fall", 32'h0, ph.main_phase_output);
		repeat (10) @(negedge clk);
	endtask : t_dt

	task t_deadtime_reset;
		wb(1'b1, ADR_DTC, 32'h0000_01FF);
		drive(3'h7, 3);
		wb(1'b0, ADR_DTC, 32'h0);
		chk("busy", 32'h1, 32'(rd[18:16]));
		wb(1'b1, ADR_CTRL, 32'h1);
		wb(1'b0, ADR_DTC, 32'h0);
		chk("busy", 32'h0, 32'(rd[18:16]));
		wb(1'b1, ADR_DTC, 32'h0);
	endtask : t_deadtime_reset

	// Without ticks the counter must stand still
	task t_tick;
		wb(1'b1, ADR_DTC, 32'h0000_0102);
		tick <= 1'b0;
		drive(3'h0, 12);
		chk("compl", 32'h6, ph.complementary_phase_output);
		@(posedge clk);
		tick <= 1'b1;
		repeat (5) @(negedge clk);
		chk("compl", 32'h7, ph.complementary_phase_output);
		wb(1'b1, ADR_DTC, 32'h0);
	endtask : t_tick

	task t_hyst;
		drive(3'h0, 3);
		@(posedge clk);
		cmp <= 3'h0;
		wb(1'b1, ADR_MODE, 32'h0000_0999);
		drive(3'h7, 8);
		wb(1'b0, ADR_STAT, 32'h0);
		chk("st", 32'h0, rd & 32'h7);
		chk("main", 32'h0, ph.main_phase_output);
		cmp <= 3'h7;
		drive(3'h7, 8);
		wb(1'b0, ADR_STAT, 32'h0);
		chk("st", 32'h7, rd & 32'h7);
		chk("main", 32'h7, ph.main_phase_output);
	endtask : t_hyst

	task t_sel_psl;
		wb(1'b1, ADR_STAT, 32'h0000_3F00);
		repeat (3) @(negedge clk);
		chk("main", 32'h0, ph.main_phase_output);
		chk("compl", 32'h7, ph.complementary_phase_output);
		wb(1'b1, ADR_STAT, 32'h0);
		wb(1'b1, ADR_PSL, 32'h0000_003F);
		wb(1'b0, ADR_PSL, 32'h0);
		chk("psl", 32'h0, rd);
		@(posedge clk);
		sht <= 1'b1;
		@(posedge clk);
		sht <= 1'b0;
		wb(1'b0, ADR_PSL, 32'h0);
		chk("psl", 32'h3F, rd);
		repeat (3) @(negedge clk);
		chk("main", 32'h0, ph.main_phase_output);
		chk("compl", 32'h7, ph.complementary_phase_output);
	endtask : t_sel_psl

	//------------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		miscompares = 0;
		n_tests = 0;
		rst = 1'b1;
		req = '0;
		tick = 1'b1;
		sht = 1'b0;
		st_req = 3'h0;
		cmp = 3'h7;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_nodt();
		t_dt();
		t_deadtime_reset();
		t_tick();
		t_hyst();
		t_sel_psl();
		chk("shoot", 32'h0, 32'(shoots));
		report_and_stop();
	end
endmodule : testbench
